/* File: rtl/analog_ctrl.sv */
// Operation
// RULE_01 - Converter clock from 16MHz divided to 2MHz, 1MHz, 500kHz or 250kHz.
// RULE_02 - Sample input for 2, 4, 6 or 8 converter clocks, then hold.
// RULE_03 - Conversion lasts three sample periods plus fourteen converter clocks.
// RULE_04 - Single and continuous modes; continuous restarts right after completion.
// RULE_05 - Twelve-bit converter selects one of six single-ended input channels.
// RULE_06 - Gain 0 ranges to reference, gain 1 to twice the reference.
// RULE_07 - One shared reference select; input and output gains independent.
// RULE_08 - Completion raises enabled interrupt and sets pollable done status.
// RULE_09 - Accumulator sums 2, 4, 8 or 16 results; interrupt optionally deferred.
// RULE_10 - Supply divider chain enabled only while that channel is measured.
// RULE_11 - Two output channels of 11 bits, each with own range.
// RULE_12 - Each output channel range configurable independently.
// RULE_13 - Output conversion uses same timing; updates allowed during input conversion.
// RULE_14 - Divider, interrupt enable and reference select shared by both converters.
// RULE_15 - Each output channel exposes a pollable busy indication.
// RULE_16 - Disabling output converter asserts its power-down control; code has one shared power-down, set only when both channels are disabled.
// RULE_17 - Output channels never convert together; software interleaves with retain bits.
// RULE_18 - Software should run output converters only in continuous mode.
// RULE_19 - One shared hysteresis setting for both comparators: 0, 10, 20, 40mV.
// RULE_20 - Each comparator negative input: reference, its output channel, or pin.
// RULE_21 - Comparator outputs readable, can interrupt; each has power-saving disable.
// RULE_22 - Comparator low-power mode, wake edge select; sleep needs pin negative input.
// RULE_23 - Accumulator clears at period start, holds sum until read or new period.
`timescale 1ns/1ps
`default_nettype none

module analog_ctrl
	import analog_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic                           clk_i,
	input  wire logic                           rstn_i,
	// Configuration
	input  wire analog_ctrl_pkg::shared_cfg_type shared_i,
	input  wire analog_ctrl_pkg::adc_cfg_type    adc_i,
	input  wire analog_ctrl_pkg::dac_cfg_type    first_output_converter_i,
	input  wire analog_ctrl_pkg::dac_cfg_type    second_output_converter_i,
	input  wire analog_ctrl_pkg::comp_cfg_type   first_comparator_i,
	input  wire analog_ctrl_pkg::comp_cfg_type   second_comparator_i,
	input  wire logic [1:0]                      hysteresis_i,
	input  wire logic                           done_clear_i,
	// Analogue cells
	input  wire logic [`ADC_BITS-1:0]            adc_result_i,
	input  wire logic [1:0]                      comp_out_i,
	output logic                                 dummy_unused_o,
	output var analog_ctrl_pkg::analog_ctl_type  analog_o,
	// Status
	output logic [`ADC_BITS-1:0]                 adc_data_o,
	output logic [`ACC_BITS-1:0]                 acc_sum_o,
	output logic                                 adc_busy_o,
	output logic                                 adc_done_o,
	output logic                                 adc_irq_o,
	output logic [1:0]                           dac_busy_o,
	output logic [1:0]                           comp_status_o,
	output logic [1:0]                           comp_irq_o,
	output logic [1:0]                           comp_wake_o
);
	import analog_ctrl_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [5:0]            div_cnt;
		logic                  conv_clk;
		conv_state_type        adc_state;
		logic [4:0]            adc_cnt;
		logic [4:0]            adc_sample_len;
		logic [1:0]            dac_state;
		logic [5:0]            dac_cnt;
		logic                  adc_busy;
		logic                  dac_sel;
		logic [4:0]            acc_cnt;
		logic [`ACC_BITS-1:0]  acc;
		logic [2:0][1:0]       comp_sync;
		logic [1:0]            comp_stable;
		analog_ctl_type        ctl;
		logic [`ADC_BITS-1:0]  adc_data;
		logic [`ACC_BITS-1:0]  acc_sum;
		logic                  adc_done;
		logic                  adc_irq;
		logic [1:0]            dac_busy;
		logic [1:0]            comp_irq;
		logic [1:0]            comp_wake;
	} state_type;

	state_type st;
	state_type next_st;

	function automatic logic [5:0] half_period(input clk_div_type d);
		case (d)
			DIV_2MHZ:   half_period = `CONV_HALF_2MHZ;
			DIV_1MHZ:   half_period = `CONV_HALF_1MHZ;
			DIV_500KHZ: half_period = `CONV_HALF_500KHZ;
			default:    half_period = `CONV_HALF_250KHZ;
		endcase
	endfunction

	// Sample clocks: 2, 4, 6 or 8
	function automatic logic [4:0] sample_clks(input logic [1:0] s);
		sample_clks = 5'(({3'd0, s} + 5'd1) * `SAMPLE_UNIT);
	endfunction

	// Hold time after sampling: 2*sample + 14 makes total 3*sample + 14
	function automatic logic [4:0] hold_clks(input logic [1:0] s);
		hold_clks = 5'(sample_clks(s) * (`SAMPLE_MULT - 5'd1) + `CONV_EXTRA_CLKS);
	endfunction

	function automatic logic [4:0] acc_target(input logic [1:0] l);
		acc_target = 5'(5'd2 << l);
	endfunction

	logic conv_tick;
	logic adc_complete;
	logic [1:0] dac_req;
	logic [1:0] comp_rise;
	logic [1:0] comp_fall;

	always_comb begin
		next_st = st;

		// ==========================================================
		// Converter clock divider
		conv_tick = 1'b0;
		if (st.div_cnt >= half_period(shared_i.div) - 6'd1) begin // see RULE_01
			next_st.div_cnt = 6'd0;
			next_st.conv_clk = ~st.conv_clk;
			conv_tick = st.conv_clk;
		end else begin
			next_st.div_cnt = st.div_cnt + 6'd1;
		end

		// ==========================================================
		// Input converter sequencing
		adc_complete = 1'b0;
		case (st.adc_state)
			CONV_IDLE: begin
				if (adc_i.enable && (adc_i.start || adc_i.continuous) && adc_i.channel <= `CH_LAST && conv_tick) begin
					next_st.adc_state = CONV_SAMPLE; // see RULE_05
					next_st.adc_sample_len = sample_clks(adc_i.sample_sel);
					next_st.adc_cnt = sample_clks(adc_i.sample_sel) - 5'd1; // see RULE_02
					next_st.ctl.adc_channel = adc_i.channel;
				end
			end
			CONV_SAMPLE: begin
				if (conv_tick) begin
					if (st.adc_cnt == 5'd0) begin
						next_st.adc_state = CONV_HOLD;
						next_st.adc_cnt = hold_clks(adc_i.sample_sel) - 5'd1; // see RULE_03
					end else begin
						next_st.adc_cnt = st.adc_cnt - 5'd1;
					end
				end
			end
			CONV_HOLD: begin
				if (conv_tick) begin
					if (st.adc_cnt == 5'd0) begin
						adc_complete = 1'b1;
						// Continuous mode starts again at once
						if (adc_i.enable && adc_i.continuous) begin // see RULE_04
							next_st.adc_state = CONV_SAMPLE;
							next_st.adc_cnt = sample_clks(adc_i.sample_sel) - 5'd1;
							next_st.ctl.adc_channel = adc_i.channel;
						end else begin
							next_st.adc_state = CONV_IDLE;
						end
					end else begin
						next_st.adc_cnt = st.adc_cnt - 5'd1;
					end
				end
			end
			default: next_st.adc_state = CONV_IDLE;
		endcase
		if (!adc_i.enable)
			next_st.adc_state = CONV_IDLE;

		next_st.ctl.adc_sample = (next_st.adc_state == CONV_SAMPLE);
		next_st.adc_busy = (next_st.adc_state != CONV_IDLE);
		next_st.ctl.adc_clk = next_st.conv_clk;
		next_st.ctl.adc_gain = adc_i.gain; // see RULE_06
		next_st.ctl.ref_sel = shared_i.ref_sel; // see RULE_07
		next_st.ctl.supply_divider_on = (next_st.adc_state != CONV_IDLE)
			&& (next_st.ctl.adc_channel == `CH_SUPPLY); // see RULE_10

		// ==========================================================
		// Results, accumulator and completion flags
		if (adc_complete)
			next_st.adc_data = adc_result_i;
		if (adc_i.acc_read)
			next_st.acc_sum = '0; // see RULE_23
		next_st.adc_irq = 1'b0;
		if (adc_complete) begin
			if (adc_i.acc_enable) begin
				if (st.acc_cnt == 5'd0)
					next_st.acc = `ACC_BITS'(adc_result_i); // see RULE_23
				else
					next_st.acc = st.acc + `ACC_BITS'(adc_result_i); // see RULE_09
				if (st.acc_cnt + 5'd1 >= acc_target(adc_i.acc_len)) begin
					next_st.acc_cnt = 5'd0;
					next_st.acc_sum = next_st.acc;
					next_st.adc_irq = shared_i.int_enable; // see RULE_09
					next_st.adc_done = 1'b1;
				end else begin
					next_st.acc_cnt = st.acc_cnt + 5'd1;
					if (!adc_i.acc_int_defer) begin
						next_st.adc_irq = shared_i.int_enable; // see RULE_08
						next_st.adc_done = 1'b1;
					end
				end
			end else begin
				next_st.acc_cnt = 5'd0;
				next_st.adc_irq = shared_i.int_enable; // see RULE_14
				next_st.adc_done = 1'b1; // see RULE_08
			end
		end else if (done_clear_i) begin
			next_st.adc_done = 1'b0;
		end
		if (!adc_i.acc_enable)
			next_st.acc_cnt = 5'd0;

		// ==========================================================
		// Output converters, one channel at a time
		dac_req = {second_output_converter_i.enable, first_output_converter_i.enable};
		case (st.dac_state)
			2'd0: begin
				// A channel starts only when it alone is enabled; with both enabled neither starts
				if (conv_tick && (dac_req == 2'b01 || dac_req == 2'b10)) begin // see RULE_17
					next_st.dac_state = 2'd1;
					next_st.dac_sel = dac_req[1];
					// Up to 38 converter clocks, so one bit wider than the input side
					next_st.dac_cnt = 6'({1'b0, sample_clks(adc_i.sample_sel)}
						+ {1'b0, hold_clks(adc_i.sample_sel)} - 6'd1); // see RULE_13
				end
			end
			2'd1: begin
				if (conv_tick) begin
					if (st.dac_cnt == 6'd0)
						next_st.dac_state = 2'd0;
					else
						next_st.dac_cnt = st.dac_cnt - 6'd1;
				end
			end
			default: next_st.dac_state = 2'd0;
		endcase
		next_st.dac_busy = '0;
		if (next_st.dac_state == 2'd1)
			next_st.dac_busy[next_st.dac_sel] = 1'b1; // see RULE_15
		next_st.ctl.dac_convert = next_st.dac_busy;
		next_st.ctl.dac_value = next_st.dac_sel ? second_output_converter_i.value
			: first_output_converter_i.value; // see RULE_11
		next_st.ctl.dac_range = {second_output_converter_i.range, first_output_converter_i.range}; // see RULE_12
		next_st.ctl.dac_retain = {second_output_converter_i.retain, first_output_converter_i.retain};
		next_st.ctl.dac_powerdown = ~(first_output_converter_i.enable
			| second_output_converter_i.enable); // see RULE_16

		// ==========================================================
		// Comparators
		next_st.comp_sync = {st.comp_sync[1:0], comp_out_i};
		if (st.comp_sync[1] == st.comp_sync[2])
			next_st.comp_stable = st.comp_sync[2];
		comp_rise = next_st.comp_stable & ~st.comp_stable;
		comp_fall = ~next_st.comp_stable & st.comp_stable;
		next_st.comp_irq = (comp_rise | comp_fall)
			& {second_comparator_i.enable, first_comparator_i.enable}; // see RULE_21
		next_st.comp_wake[0] = first_comparator_i.wake_enable
			& (first_comparator_i.wake_falling ? comp_fall[0] : comp_rise[0]); // see RULE_22
		next_st.comp_wake[1] = second_comparator_i.wake_enable
			& (second_comparator_i.wake_falling ? comp_fall[1] : comp_rise[1]);
		next_st.ctl.hysteresis = hysteresis_i; // see RULE_19
		next_st.ctl.comp_enable = {second_comparator_i.enable, first_comparator_i.enable};
		next_st.ctl.comp_low_power = {second_comparator_i.low_power, first_comparator_i.low_power};
		next_st.ctl.first_comparator_negative_input = first_comparator_i.neg_sel; // see RULE_20
		next_st.ctl.second_comparator_negative_input = second_comparator_i.neg_sel;
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			st <= '0;
			st.adc_state <= CONV_IDLE;
			st.ctl.dac_powerdown <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign dummy_unused_o = 1'b0;
	assign analog_o = st.ctl;
	assign adc_data_o = st.adc_data;
	assign acc_sum_o = st.acc_sum;
	assign adc_busy_o = st.adc_busy;
	assign adc_done_o = st.adc_done;
	assign adc_irq_o = st.adc_irq;
	assign dac_busy_o = st.dac_busy;
	assign comp_status_o = st.comp_stable;
	assign comp_irq_o = st.comp_irq;
	assign comp_wake_o = st.comp_wake;
endmodule

`default_nettype wire

/* File: rtl/analog_ctrl_pkg.sv */
package analog_ctrl_pkg;
	`include "analog_ctrl_regs.svh"

	typedef enum logic [1:0] {DIV_2MHZ, DIV_1MHZ, DIV_500KHZ, DIV_250KHZ} clk_div_type;
	typedef enum logic [1:0] {NEG_REF, NEG_OUT_CONV, NEG_PIN, NEG_RSVD} neg_sel_type;
	typedef enum logic {REF_BANDGAP, REF_PIN} ref_sel_type;

	typedef struct packed {
		clk_div_type div;
		logic        int_enable;
		ref_sel_type ref_sel;
	} shared_cfg_type;

	typedef struct packed {
		logic        enable;
		logic        continuous;
		logic        start;
		logic [1:0]  sample_sel;
		logic [2:0]  channel;
		logic        gain;
		logic        acc_enable;
		logic [1:0]  acc_len;
		logic        acc_int_defer;
		logic        acc_read;
	} adc_cfg_type;

	typedef struct packed {
		logic                  enable;
		logic                  range;
		logic                  retain;
		logic                  write;
		logic [`DAC_BITS-1:0]  value;
	} dac_cfg_type;

	typedef struct packed {
		logic        enable;
		logic        low_power;
		logic        wake_enable;
		logic        wake_falling;
		neg_sel_type neg_sel;
	} comp_cfg_type;

	typedef struct packed {
		logic                  adc_sample;
		logic                  adc_clk;
		logic [2:0]            adc_channel;
		logic                  adc_gain;
		logic                  supply_divider_on;
		logic                  ref_sel;
		logic                  dac_powerdown;
		logic [1:0]            dac_range;
		logic [1:0]            dac_retain;
		logic [1:0]            dac_convert;
		logic [`DAC_BITS-1:0]  dac_value;
		logic [1:0]            hysteresis;
		logic [1:0]            comp_enable;
		logic [1:0]            comp_low_power;
		neg_sel_type           first_comparator_negative_input;
		neg_sel_type           second_comparator_negative_input;
	} analog_ctl_type;

	typedef enum {CONV_IDLE, CONV_SAMPLE, CONV_HOLD} conv_state_type;
endpackage

/* File: rtl/analog_ctrl_regs.svh */
`ifndef ANALOG_CTRL_REGS_SVH
`define ANALOG_CTRL_REGS_SVH

// Clock divider: 16 MHz down to 2 MHz, 1 MHz, 500 kHz, 250 kHz (half periods)
`define SRC_CLK_MHZ        16
`define CONV_HALF_2MHZ     6'd4
`define CONV_HALF_1MHZ     6'd8
`define CONV_HALF_500KHZ   6'd16
`define CONV_HALF_250KHZ   6'd32

// Conversion timing in converter clocks
`define SAMPLE_UNIT        5'd2
`define SAMPLE_MULT        5'd3
`define CONV_EXTRA_CLKS    5'd14

// Channel codes
`define CH_SUPPLY          3'd5
`define CH_LAST            3'd5

// Field widths
`define ADC_BITS           12
`define DAC_BITS           11
`define ACC_BITS           16

`endif

/* File: testbench/analog_cell_model.sv */
`timescale 1ns/1ps
`default_nettype none
module analog_cell_model
	import analog_ctrl_pkg::*;
(
	// Clock
	input  wire logic                           clk_i,
	// Cell controls and comparator levels
	input  wire analog_ctrl_pkg::analog_ctl_type analog_i,
	input  wire logic [1:0]                      level_i,
	// Cell outputs
	output logic [11:0]                          result_o,
	output logic [1:0]                           comp_o
);
	logic held;
	initial result_o = 12'h000;
	// Result is junk while tracking, so a capture too early shows up
	always @(posedge clk_i) begin
		held <= analog_i.adc_sample;
		if (analog_i.adc_sample)
			result_o <= ~result_o;
		else if (held)
			result_o <= {analog_i.adc_channel, analog_i.adc_gain, 8'ha5};
	end
	assign comp_o = level_i;
endmodule
`default_nettype wire

/* File: testbench/analog_ctrl_props.sv */
`timescale 1ns/1ps
`default_nettype none
module analog_ctrl_props
	import analog_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic                           clk_i,
	input wire logic                           rstn_i,
	// Watched inputs
	input wire analog_ctrl_pkg::shared_cfg_type shared_i,
	input wire analog_ctrl_pkg::adc_cfg_type    adc_i,
	input wire analog_ctrl_pkg::dac_cfg_type    first_output_converter_i,
	input wire analog_ctrl_pkg::dac_cfg_type    second_output_converter_i,
	input wire analog_ctrl_pkg::comp_cfg_type   first_comparator_i,
	input wire logic [1:0]                      hysteresis_i,
	input wire logic                           done_clear_i,
	// Watched outputs
	input wire analog_ctrl_pkg::analog_ctl_type analog_o,
	input wire logic                           adc_done_o,
	input wire logic                           adc_irq_o,
	input wire logic [1:0]                      dac_busy_o,
	input wire logic [1:0]                      comp_wake_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// ====================
	// Cycles since the last rise of the sample strobe
	logic [15:0] gap;
	logic [15:0] per;
	logic [15:0] samp;
	logic [15:0] conv;
	logic        prev_s;
	logic        seen;
	assign per = 16'd8 << shared_i.div;
	assign samp = (16'(adc_i.sample_sel) + 16'd1) * 16'd2 * per;
	assign conv = ((16'(adc_i.sample_sel) + 16'd1) * 16'd6 + 16'd14) * per;
	always_ff @(posedge clk_i) begin
		prev_s <= analog_o.adc_sample;
		if (!rstn_i || !adc_i.enable || !adc_i.continuous)
			seen <= 1'b0;
		else if (analog_o.adc_sample && !prev_s)
			seen <= 1'b1;
		if (analog_o.adc_sample && !prev_s)
			gap <= 16'd1;
		else
			gap <= gap + 16'd1;
	end
	// ====================
	// Assertions
	a_sample_len: assert property ($fell(analog_o.adc_sample) && adc_i.enable |-> gap == samp)
		else $error("sample window length wrong");
	a_conv_period: assert property (analog_o.adc_sample && !prev_s && seen |-> gap == conv)
		else $error("continuous conversion period wrong");
	a_irq_pulse: assert property (adc_irq_o |=> !adc_irq_o)
		else $error("end of conversion pulse too long");
	a_irq_gated: assert property (adc_irq_o |-> $past(shared_i.int_enable) && adc_done_o)
		else $error("interrupt without enable or status");
	a_done_hold: assert property (adc_done_o && !done_clear_i |=> adc_done_o)
		else $error("done status dropped early");
	a_supply_gate: assert property (analog_o.supply_divider_on |-> analog_o.adc_channel == 3'h5)
		else $error("supply divider on for other channel");
	a_dac_single: assert property (!(&analog_o.dac_convert) && !(&dac_busy_o))
		else $error("both output channels converting");
	a_dac_pdown: assert property ((!first_output_converter_i.enable && !second_output_converter_i.enable) [*2]
		|-> analog_o.dac_powerdown)
		else $error("output converter not powered down");
	a_dac_awake: assert property ((first_output_converter_i.enable && !second_output_converter_i.enable) [*2]
		|-> !analog_o.dac_powerdown)
		else $error("output converter powered down while enabled");
	a_cfg_route: assert property ($past(rstn_i) |-> analog_o.hysteresis == $past(hysteresis_i)
		&& analog_o.first_comparator_negative_input == $past(first_comparator_i.neg_sel))
		else $error("comparator settings not routed");
	a_wake_gate: assert property (comp_wake_o[0] |-> $past(first_comparator_i.wake_enable))
		else $error("wake without enable");
	c_defer: cover property (adc_irq_o && adc_i.acc_int_defer);
	c_supply: cover property (analog_o.supply_divider_on);
	c_second_dac: cover property ($rose(dac_busy_o[1]));
endmodule
bind analog_ctrl analog_ctrl_props u_props (.clk_i, .rstn_i, .shared_i, .adc_i, .first_output_converter_i,
	.second_output_converter_i, .first_comparator_i, .hysteresis_i, .done_clear_i, .analog_o, .adc_done_o,
	.adc_irq_o, .dac_busy_o, .comp_wake_o);
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import analog_ctrl_pkg::*;
	typedef struct packed {logic [11:0] d; logic [15:0] a; logic ca;} note_type;
	logic           clk_i, rstn_i, done_clear_i, adc_busy, adc_done, adc_irq, prev_done;
	shared_cfg_type shared_i;
	adc_cfg_type    adc_i;
	dac_cfg_type    dac0, first_output_converter;
	comp_cfg_type   cmp0, cmp1;
	logic [1:0]     hysteresis_i, level, comp_out, dac_busy, comp_status, comp_irq, comp_wake;
	logic [11:0]    adc_result, adc_data, v;
	logic [15:0]    acc_sum;
	analog_ctl_type analog;
	note_type       notes[$];
	note_type       n;
	int             bad_count, n_compared, wk0, wk1, ci;

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	analog_ctrl DUT (.clk_i, .rstn_i, .shared_i, .adc_i, .first_output_converter_i(dac0),
		.second_output_converter_i(first_output_converter), .first_comparator_i(cmp0), .second_comparator_i(cmp1),
		.hysteresis_i, .done_clear_i, .adc_result_i(adc_result), .comp_out_i(comp_out), .dummy_unused_o(),
		.analog_o(analog), .adc_data_o(adc_data), .acc_sum_o(acc_sum), .adc_busy_o(adc_busy),
		.adc_done_o(adc_done), .adc_irq_o(adc_irq), .dac_busy_o(dac_busy), .comp_status_o(comp_status),
		.comp_irq_o(comp_irq), .comp_wake_o(comp_wake));
	analog_cell_model model (.clk_i, .analog_i(analog), .level_i(level), .result_o(adc_result), .comp_o(comp_out));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask
	task automatic wait_hi(ref logic s, input int lim);
		for (int i = 0; i < lim && s !== 1'b1; i++)
			step(1);
		chk("wait", 16'd1, 16'(s));
	endtask
	task automatic clear_done;
		done_clear_i = 1'b1;
		step(1);
		done_clear_i = 1'b0;
		step(1);
	endtask

	// ====================
	// Result monitor: each completion takes the oldest note
	always @(posedge clk_i) begin
		prev_done <= adc_done;
		if (rstn_i && (adc_irq === 1'b1 || (adc_done === 1'b1 && prev_done !== 1'b1))) begin
			if (notes.size() == 0) begin
				chk("spare result", 16'd0, 16'd1);
			end else begin
				n = notes.pop_front();
				chk("result", 16'(n.d), 16'(adc_data));
				chk("done", 16'd1, 16'(adc_done));
				if (n.ca)
					chk("sum", n.a, acc_sum);
			end
		end
	end
	always @(posedge clk_i) begin
		if (comp_wake[0] === 1'b1)
			wk0++;
		if (comp_wake[1] === 1'b1)
			wk1++;
		if (comp_irq[0] === 1'b1)
			ci++;
		if (comp_irq[1] === 1'b1)
			ci++;
	end
	initial begin
		#900us;
		bad_count++;
		report_and_stop();
	end

	// ====================
	// Main sequence
	initial begin
		int ch;
		int k;
		void'($urandom(32'h9d46));
		{rstn_i, done_clear_i, shared_i, adc_i, dac0, first_output_converter, cmp0, cmp1, hysteresis_i, level} = '0;
		{bad_count, n_compared, wk0, wk1, ci} = '0;
		step(20);
		rstn_i = 1'b1;
		step(2);
		chk("powerdown", 16'd1, 16'(analog.dac_powerdown));
		// Single shots on every channel and gain; last two polled only
		for (ch = 0; ch < 12; ch++) begin
			shared_i = '{clk_div_type'($urandom_range(3)), ch < 10, ref_sel_type'(ch % 2)};
			hysteresis_i = 2'($urandom_range(3));
			cmp0.neg_sel = neg_sel_type'($urandom_range(2));
			adc_i.sample_sel = 2'($urandom_range(3));
			adc_i.channel = 3'(ch / 2);
			adc_i.gain = 1'(ch);
			notes.push_back('{{3'(ch / 2), 1'(ch), 8'ha5}, 16'd0, 1'b0});
			adc_i.enable = 1'b1;
			adc_i.start = 1'b1;
			wait_hi(adc_busy, 600);
			adc_i.start = 1'b0;
			wait_hi(adc_done, 3000);
			step(2);
			clear_done();
			chk("done clear", 16'd0, 16'(adc_done));
		end
		// Continuous runs, interrupt held back to the end of each sum
		for (k = 0; k < 4; k++) begin
			shared_i = '{DIV_2MHZ, 1'b1, REF_BANDGAP};
			v = {3'(k), 1'b0, 8'ha5};
			notes.push_back('{v, 16'(v) << (k + 1), 1'b1});
			adc_i = '{1'b1, 1'b1, 1'b0, 2'(k), 3'(k), 1'b0, 1'b1, 2'(k), 1'b1, 1'b0};
			wait_hi(adc_done, 6000);
			adc_i.enable = 1'b0;
			adc_i.acc_read = 1'b1;
			step(1);
			adc_i.acc_read = 1'b0;
			clear_done();
		end
		// Output channels one at a time, with retain set on both
		for (k = 0; k < 2; k++) begin
			dac0 = '{k == 0, 1'(k), 1'b1, 1'b0, 11'($urandom)};
			first_output_converter = '{k == 1, 1'(~k), 1'b1, 1'b0, 11'($urandom)};
			// A previous conversion may still run for up to 304 cycles
			for (ch = 0; ch < 700 && dac_busy[k] !== 1'b1; ch++)
				step(1);
			chk("dac busy", 16'(1 << k), 16'(dac_busy));
			chk("dac range", {14'd0, first_output_converter.range, dac0.range}, 16'(analog.dac_range));
			chk("dac value", 16'(k ? first_output_converter.value : dac0.value), 16'(analog.dac_value));
			chk("dac awake", 16'd0, 16'(analog.dac_powerdown));
		end
		dac0.enable = 1'b1;
		step(100);
		{dac0.enable, first_output_converter.enable} = 2'b00;
		step(4);
		chk("dac off", 16'd1, 16'(analog.dac_powerdown));
		// Comparators: first wakes on rising, second on falling
		cmp0 = '{1'b1, 1'b1, 1'b1, 1'b0, NEG_PIN};
		cmp1 = '{1'b1, 1'b1, 1'b1, 1'b1, NEG_PIN};
		step(12);
		level = 2'b11;
		step(12);
		chk("comp status", 16'd3, 16'(comp_status));
		chk("wake count", 16'h0001, {wk1[7:0], wk0[7:0]});
		chk("comp irq", 16'd2, 16'(ci));
		level = 2'b00;
		step(12);
		chk("comp status", 16'd0, 16'(comp_status));
		chk("wake count", 16'h0101, {wk1[7:0], wk0[7:0]});
		chk("comp irq", 16'd4, 16'(ci));
		report_and_stop();
	end
endmodule
`default_nettype wire
